//--- shared/uotg_defs.svh
// Constants for the dual-role token, configuration and event-flag block.
// Assumes a 100 MHz clock and an APB register bus with 32-bit data.
//
// Summary of operation
// - Frame threshold holds ten plus packet size; 64 bytes is 0x4A.
// - Config one bit 7 enables the eye pattern test.
// - Config one bit 6 drives active-low OE while lines driven, only if transceiver disabled.
// - Config one bit 4 halts the module while the CPU idles.
// - Ping-pong field: 11 endpoints 1-15, 10 all, 01 endpoint 0 RX, 00 off.
// - Config two bit 4 switches the bus-power sense pull-up.
// - Config two bit 3 selects serial control of external transceivers, else pins.
// - Flag bit 7 sets on any ID pin change.
// - Flag bit 6 sets each time the millisecond timer expires.
// - Flag bit 5 sets when line state is stable 1 ms and differs from last.
// - Flag bit 4 sets on activity on D+, D- or bus power.
// - Flag bit 3 sets when bus power crosses A session-end threshold.
// - Flag bit 2 sets when B-device sees B session-end crossing.
// - Flag bit 0 sets when A-device sees bus-valid crossing.
// - Power threshold flags set on rising and falling crossings.
// - Full-word write of one clears a flag; partial write clears all set flags.
// - Enable bit at the same position gates each flag onto the interrupt.
// - Token busy status shows while a host token executes.
// - J indication is differential zero at low speed, one at full speed.
`ifndef UOTG_DEFS_SVH
`define UOTG_DEFS_SVH
`define UOTG_OFF_TOK 8'h00
`define UOTG_OFF_SOF 8'h04
`define UOTG_OFF_CFG1 8'h08
`define UOTG_OFF_CFG2 8'h0C
`define UOTG_OFF_FLAGS 8'h10
`define UOTG_OFF_ENABLES 8'h14
`define UOTG_OFF_STATUS 8'h18
`define UOTG_TOK_SETUP 4'hD
`define UOTG_TOK_IN 4'h9
`define UOTG_TOK_OUT 4'h1
`define UOTG_CFG1_MASK 8'hD3
`define UOTG_CFG2_MASK 8'h19
`define UOTG_FLAG_MASK 8'hFD
`define UOTG_BIT_EYE 7
`define UOTG_BIT_OEMON 6
`define UOTG_BIT_SIDL 4
`define UOTG_BIT_PULLUP 4
`define UOTG_BIT_SERSEL 3
`define UOTG_BIT_XCVRDIS 0
`define UOTG_F_ID 7
`define UOTG_F_MS 6
`define UOTG_F_LS 5
`define UOTG_F_ACT 4
`define UOTG_F_SESV 3
`define UOTG_F_BEND 2
`define UOTG_F_AVLD 0
`define UOTG_STRB_FULL 4'hF
`define UOTG_MS_NS 1000000
`define UOTG_CLK_NS 10
`define UOTG_CNT_W 20
`endif

//--- shared/uotg_pkg.sv
// Types shared by the dual-role token and event block.
// Assumes the constants header is compiled alongside.
package uotg_pkg;
  typedef struct packed {
    logic [3:0] tokenType;
    logic [3:0] tokenEndpoint;
  } uotg_token_t;
  typedef enum logic [1:0] {
    UOTG_PP_OFF,
    UOTG_PP_EP0_RX,
    UOTG_PP_ALL,
    UOTG_PP_EP1_15
  } uotg_pingpong_t;
  typedef enum logic {
    UOTG_TOK_IDLE,
    UOTG_TOK_BUSY
  } uotg_tokstate_t;
endpackage

//--- hdl/uotg_host_cfg.sv
// Host token launch, frame threshold, transceiver config and dual-role event flags.
// Assumes an APB4 master on the same clock and sensor pins from another domain.
`include "uotg_defs.svh"
module uotg_host_cfg import uotg_pkg::*; #(
  parameter int unsigned MS_CYCLES = `UOTG_MS_NS / `UOTG_CLK_NS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hostMode,
  input wire logic cpuIdle,
  input wire logic lowSpeed,
  input wire logic tokenDone,
  input wire logic lineDriving,
  input wire logic idPin,
  input wire logic dPlus,
  input wire logic dMinus,
  input wire logic aSessEnd,
  input wire logic bSessEnd,
  input wire logic aBusValid,
  output uotg_token_t tokenCmd,
  output logic tokenStart,
  output logic tokenInProgress,
  output logic [7:0] frameThreshold,
  output logic eyeTestEnable,
  output logic xcvrOutEnable_n,
  output logic moduleHalted,
  output uotg_pingpong_t pingpongMode,
  output logic busPowerPullup,
  output logic externalCtrlSerial,
  output logic transceiverDisable,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic legalToken(input logic [3:0] code);
    legalToken = (code == `UOTG_TOK_SETUP) || (code == `UOTG_TOK_IN) || (code == `UOTG_TOK_OUT);
  endfunction

  logic [7:0] cfgOne;
  logic [7:0] cfgTwo;
  logic [7:0] flags;
  logic [7:0] enables;
  logic [7:0] flagSet;
  logic [7:0] flagClr;
  logic [7:0] next_flags;
  logic [7:0] next_enables;
  logic [2:0] senseStage;
  logic [5:0] syncA;
  logic [5:0] syncB;
  logic [5:0] syncPrev;
  logic senseValid;
  logic live_j_indication;
  logic se0;
  logic [1:0] lineNow;
  logic [1:0] lineLast;
  logic [1:0] lineStable;
  logic [`UOTG_CNT_W-1:0] msCount;
  logic [`UOTG_CNT_W-1:0] lsCount;
  logic msTick;
  logic lsTick;
  logic running;
  logic accPhase;
  logic wrDone;
  logic mapped;
  logic [7:0] rdValue;
  uotg_tokstate_t tokState;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, data and error ride with pready
  assign accPhase = psel && penable && !pready;
  assign wrDone = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    mapped = 1'b1;
    rdValue = 8'h00;
    if (paddr == `UOTG_OFF_TOK) begin
      rdValue = tokenCmd;
    end else if (paddr == `UOTG_OFF_SOF) begin
      rdValue = frameThreshold;
    end else if (paddr == `UOTG_OFF_CFG1) begin
      rdValue = cfgOne;
    end else if (paddr == `UOTG_OFF_CFG2) begin
      rdValue = cfgTwo;
    end else if (paddr == `UOTG_OFF_FLAGS) begin
      rdValue = flags;
    end else if (paddr == `UOTG_OFF_ENABLES) begin
      rdValue = enables;
    end else if (paddr == `UOTG_OFF_STATUS) begin
      rdValue = {2'b00, moduleHalted, lineStable, tokenInProgress, live_j_indication, se0};
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= accPhase;
      pslverr <= accPhase && !mapped;
      prdata <= (accPhase && !pwrite) ? {24'h00_0000, rdValue} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfgOne <= 8'h00;
      cfgTwo <= 8'h00;
      enables <= 8'h00;
      frameThreshold <= 8'h00;
    end else if (wrDone) begin
      if (paddr == `UOTG_OFF_CFG1) begin
        cfgOne <= pwdata[7:0] & `UOTG_CFG1_MASK;
      end else if (paddr == `UOTG_OFF_CFG2) begin
        cfgTwo <= pwdata[7:0] & `UOTG_CFG2_MASK;
      end else if (paddr == `UOTG_OFF_ENABLES) begin
        enables <= pwdata[7:0] & `UOTG_FLAG_MASK;
      end else if (paddr == `UOTG_OFF_SOF) begin
        frameThreshold <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      eyeTestEnable <= 1'b0;
      xcvrOutEnable_n <= 1'b1;
      moduleHalted <= 1'b0;
      pingpongMode <= UOTG_PP_OFF;
      busPowerPullup <= 1'b0;
      externalCtrlSerial <= 1'b0;
      transceiverDisable <= 1'b0;
    end else begin
      eyeTestEnable <= cfgOne[`UOTG_BIT_EYE];
      // OE only means something with the on-chip transceiver switched off
      xcvrOutEnable_n <= !(cfgOne[`UOTG_BIT_OEMON] && cfgTwo[`UOTG_BIT_XCVRDIS] && lineDriving);
      moduleHalted <= cfgOne[`UOTG_BIT_SIDL] && cpuIdle;
      pingpongMode <= uotg_pingpong_t'(cfgOne[1:0]);
      busPowerPullup <= cfgTwo[`UOTG_BIT_PULLUP];
      externalCtrlSerial <= cfgTwo[`UOTG_BIT_SERSEL];
      transceiverDisable <= cfgTwo[`UOTG_BIT_XCVRDIS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Token launch; writes while busy are stored but start nothing
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tokenCmd <= '0;
      tokenStart <= 1'b0;
      tokState <= UOTG_TOK_IDLE;
    end else begin
      tokenStart <= 1'b0;
      if (wrDone && paddr == `UOTG_OFF_TOK) begin
        tokenCmd <= pwdata[7:0];
      end
      case (tokState)
        UOTG_TOK_IDLE: begin
          if (wrDone && paddr == `UOTG_OFF_TOK && hostMode && !moduleHalted && legalToken(pwdata[7:4])) begin
            tokenStart <= 1'b1;
            tokState <= UOTG_TOK_BUSY;
          end
        end
        UOTG_TOK_BUSY: begin
          if (tokenDone) begin
            tokState <= UOTG_TOK_IDLE;
          end
        end
        default: tokState <= UOTG_TOK_IDLE;
      endcase
    end
  end
  assign tokenInProgress = (tokState == UOTG_TOK_BUSY);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: id, D+, D-, A session end, B session end, A bus valid
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 6'h00;
      syncB <= 6'h00;
      syncPrev <= 6'h00;
      senseStage <= 3'h0;
    end else begin
      syncA <= {aBusValid, bSessEnd, aSessEnd, dMinus, dPlus, idPin};
      syncB <= syncA;
      syncPrev <= syncB;
      senseStage <= {senseStage[1:0], 1'b1};
    end
  end
  // Edges count only once syncPrev holds a real pin sample, so no false edge after reset
  assign senseValid = &senseStage;

  assign se0 = !syncB[1] && !syncB[2];
  assign live_j_indication = lowSpeed ? (!syncB[1] && syncB[2]) : (syncB[1] && !syncB[2]);
  assign lineNow = {se0, live_j_indication};
  assign running = !moduleHalted;

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond timer and line-state stability counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      msCount <= '0;
    end else if (running) begin
      msCount <= msTick ? '0 : msCount + 1'b1;
    end
  end
  assign msTick = running && (msCount == `UOTG_CNT_W'(MS_CYCLES - 1));

  // Stable state only reported once per change, hence lineStable compare
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lsCount <= '0;
      lineLast <= 2'b00;
      lineStable <= 2'b00;
    end else if (running) begin
      lineLast <= lineNow;
      if (lineNow != lineLast) begin
        lsCount <= '0;
      end else if (lsCount != `UOTG_CNT_W'(MS_CYCLES - 1)) begin
        lsCount <= lsCount + 1'b1;
      end
      if (lsTick) begin
        lineStable <= lineNow;
      end
    end
  end
  assign lsTick = running && (lineNow == lineLast) && (lsCount == `UOTG_CNT_W'(MS_CYCLES - 2))
    && (lineNow != lineStable);

  ////////////////////////////////////////////////////////////////////////////
  // Event flags: set wins over clear in the same cycle
  always_comb begin
    flagSet = 8'h00;
    flagSet[`UOTG_F_ID] = senseValid && (syncB[0] != syncPrev[0]);
    flagSet[`UOTG_F_MS] = msTick;
    flagSet[`UOTG_F_LS] = lsTick;
    flagSet[`UOTG_F_ACT] = senseValid && (syncB[5:1] != syncPrev[5:1]);
    flagSet[`UOTG_F_SESV] = senseValid && (syncB[3] != syncPrev[3]);
    flagSet[`UOTG_F_BEND] = senseValid && syncB[0] && (syncB[4] != syncPrev[4]);
    flagSet[`UOTG_F_AVLD] = senseValid && !syncB[0] && (syncB[5] != syncPrev[5]);
    flagClr = 8'h00;
    if (wrDone && paddr == `UOTG_OFF_FLAGS) begin
      flagClr = (pstrb == `UOTG_STRB_FULL) ? pwdata[7:0] : 8'hFF;
    end
    next_flags = ((flags & ~flagClr) | flagSet) & `UOTG_FLAG_MASK;
    // Irq follows the enable written in the same edge, so it never lags the register
    next_enables = enables;
    if (wrDone && paddr == `UOTG_OFF_ENABLES) begin
      next_enables = pwdata[7:0] & `UOTG_FLAG_MASK;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags <= 8'h00;
      irq <= 1'b0;
    end else begin
      flags <= next_flags;
      irq <= |(next_flags & next_enables);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence tokWriteS;
    wrDone && paddr == `UOTG_OFF_TOK;
  endsequence
  sequence legalLaunchS;
    tokWriteS ##0 (hostMode && !moduleHalted && !tokenInProgress && legalToken(pwdata[7:4]));
  endsequence

  token_launch_a: assert property (legalLaunchS |=> tokenStart ##1 tokenInProgress)
    else $error("token write did not launch");
  token_legal_a: assert property (tokenStart |-> legalToken(tokenCmd.tokenType))
    else $error("reserved token type launched");
  token_busy_a: assert property (tokenInProgress && !tokenDone |=> tokenInProgress && !tokenStart)
    else $error("busy dropped without done");
  irq_gate_a: assert property (|(flags & enables) |-> irq)
    else $error("irq missing for enabled flag");
  irq_quiet_a: assert property (irq |-> |(flags & enables))
    else $error("irq without enabled flag");
  flag_partial_a: assert property (wrDone && paddr == `UOTG_OFF_FLAGS && pstrb != `UOTG_STRB_FULL
    |=> (flags & ~$past(flagSet)) == 8'h00)
    else $error("partial write left flags set");
  flag_keep_a: assert property (wrDone && paddr == `UOTG_OFF_FLAGS && pstrb == `UOTG_STRB_FULL
    |=> (flags & ~$past(pwdata[7:0]) & `UOTG_FLAG_MASK)
    == (($past(flags) | $past(flagSet)) & ~$past(pwdata[7:0]) & `UOTG_FLAG_MASK))
    else $error("full write cleared unselected flag");
  id_flag_a: assert property ($changed(syncB[0]) && senseValid |=> flags[`UOTG_F_ID])
    else $error("id change not flagged");
  ms_flag_a: assert property (msTick |=> flags[`UOTG_F_MS] ##1 !msTick [*8])
    else $error("timer tick not flagged");
  oe_gate_a: assert property (!xcvrOutEnable_n |-> $past(cfgOne[`UOTG_BIT_OEMON] && cfgTwo[`UOTG_BIT_XCVRDIS]))
    else $error("oe driven while monitor off");
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered");

endmodule // uotg_host_cfg

//--- sim/uotg_peer_model.sv
// Partner model: serial engine plus attached peripheral answering host tokens.
// Assumes the block's clock and reset; respDelay of one or more cycles.
module uotg_peer_model import uotg_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tokenStart,
  input wire logic [7:0] respDelay,
  output logic tokenDone,
  output logic lineDriving
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] count;
  // Every endpoint the bench names exists here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
      tokenDone <= 1'b0;
      lineDriving <= 1'b0;
    end else begin
      tokenDone <= 1'b0;
      if (tokenStart) begin // One transaction per launch
        count <= respDelay;
        lineDriving <= 1'b1;
      end else if (count > 8'h01) begin
        count <= count - 8'h01;
      end else if (count == 8'h01) begin
        count <= 8'h00;
        tokenDone <= 1'b1;
        lineDriving <= 1'b0;
      end
    end
  end
endmodule // uotg_peer_model

//--- sim/test_usb_otg_host_token_config_irq.sv
// Testbench: APB sequences against the token, config and event flag block.
// Assumes the partner model answers tokens; pins change well apart.
`include "uotg_defs.svh"
module test_usb_otg_host_token_config_irq import uotg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 20;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, hostMode, cpuIdle, lowSpeed;
  logic tokenDone, lineDriving, idPin, dPlus, dMinus, aSessEnd, bSessEnd, aBusValid;
  logic tokenStart, tokenInProgress, eyeTestEnable, xcvrOutEnable_n, moduleHalted;
  logic busPowerPullup, externalCtrlSerial, transceiverDisable, irq, rdErr;
  logic [7:0] paddr, frameThreshold, peerDelay;
  logic [31:0] pwdata, prdata, rdData;
  logic [3:0] pstrb;
  logic [3:0] types [3] = '{`UOTG_TOK_SETUP, `UOTG_TOK_IN, `UOTG_TOK_OUT};
  uotg_token_t tokenCmd;
  uotg_pingpong_t pingpongMode;
  int n_fail = 0;
  int compares = 0;
  int nStarts = 0;
  int n0;
  uotg_host_cfg #(.MS_CYCLES(MS)) i_uotg_host_cfg (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .hostMode, .cpuIdle, .lowSpeed, .tokenDone, .lineDriving,
    .idPin, .dPlus, .dMinus, .aSessEnd, .bSessEnd, .aBusValid, .tokenCmd, .tokenStart, .tokenInProgress,
    .frameThreshold, .eyeTestEnable, .xcvrOutEnable_n, .moduleHalted, .pingpongMode, .busPowerPullup,
    .externalCtrlSerial, .transceiverDisable, .irq);
  uotg_peer_model i_uotg_peer_model (.clock, .rst_n, .tokenStart, .respDelay(peerDelay), .tokenDone,
    .lineDriving);
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (tokenStart === 1'b1) nStarts++;
  initial begin
    repeat (50000) @(posedge clock);
    n_fail++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("mismatches %0d of %0d compares", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until pready seen at an edge; no cycle count assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdData = prdata;
    rdErr = pslverr;
    if (n >= 20) begin
      n_fail++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, `UOTG_STRB_FULL);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    check(rdData & m, e);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (tokenInProgress !== 1'b0 && n < 200) begin
      @(posedge clock);
      n++;
    end
    check(32'(n < 200), 32'h1);
  endtask
  task automatic pin_flags(input logic [31:0] e);
    waitc(6);
    rdc(`UOTG_OFF_FLAGS, 32'h9D, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0;
    hostMode = 1'b1; cpuIdle = 1'b0; lowSpeed = 1'b0; idPin = 1'b1; dPlus = 1'b1; dMinus = 1'b0;
    aSessEnd = 1'b0; bSessEnd = 1'b0; aBusValid = 1'b0; peerDelay = 8'h0A;
    waitc(16);
    rst_n <= 1'b1;
    // Reset values; timer-driven flag bits masked out
    for (int a = 0; a < 6; a++) rdc(8'(a * 4), 32'hFFFFFF9F, 32'h0);
    apb(1'b0, 8'h1C, 32'h0, 4'h0);
    check({31'h0, rdErr}, 32'h1);
    wr(`UOTG_OFF_CFG1, 32'hFFFFFFFF);
    rdc(`UOTG_OFF_CFG1, 32'hFFFFFFFF, 32'hD3);
    waitc(2);
    check(32'({eyeTestEnable, moduleHalted}), 32'h2);
    for (int p = 0; p < 4; p++) begin
      wr(`UOTG_OFF_CFG1, 32'(p));
      waitc(2);
      check(32'(pingpongMode), 32'(p));
    end
    wr(`UOTG_OFF_CFG2, 32'hFFFFFFFF);
    rdc(`UOTG_OFF_CFG2, 32'hFFFFFFFF, 32'h19);
    waitc(2);
    check(32'({busPowerPullup, externalCtrlSerial, transceiverDisable}), 32'h7);
    wr(`UOTG_OFF_CFG2, 32'h01);
    waitc(2);
    check(32'({busPowerPullup, externalCtrlSerial, transceiverDisable}), 32'h1);
    wr(`UOTG_OFF_SOF, 32'h14A);
    rdc(`UOTG_OFF_SOF, 32'hFFFFFFFF, 32'h4A);
    check(32'(frameThreshold), 32'h4A);
    // Halt in idle blocks a launch
    wr(`UOTG_OFF_CFG1, 32'h10);
    cpuIdle <= 1'b1;
    n0 = nStarts;
    wr(`UOTG_OFF_TOK, 32'h91);
    waitc(3);
    check(32'({eyeTestEnable, moduleHalted}), 32'h1);
    check(32'(nStarts), 32'(n0));
    cpuIdle <= 1'b0;
    wr(`UOTG_OFF_CFG1, 32'h40);
    for (int i = 0; i < 3; i++) begin
      n0 = nStarts;
      wr(`UOTG_OFF_TOK, 32'({types[i], 4'(i + 3)}));
      waitc(4);
      check(32'(nStarts), 32'(n0 + 1));
      check(32'(tokenCmd), 32'({types[i], 4'(i + 3)}));
      check(32'(xcvrOutEnable_n), 32'h0);
      rdc(`UOTG_OFF_STATUS, 32'h4, 32'h4);
      wait_idle();
    end
    wr(`UOTG_OFF_TOK, 32'h25);
    waitc(3);
    check(32'(nStarts), 32'(n0 + 1));
    peerDelay <= 8'h28;
    wr(`UOTG_OFF_TOK, 32'h91);
    wr(`UOTG_OFF_TOK, 32'h12);
    waitc(3);
    check(32'(nStarts), 32'(n0 + 2));
    wait_idle();
    hostMode <= 1'b0;
    wr(`UOTG_OFF_TOK, 32'hD0);
    waitc(3);
    check(32'(nStarts), 32'(n0 + 2));
    hostMode <= 1'b1;
    // Event flags, enables and interrupt
    wr(`UOTG_OFF_ENABLES, 32'hFF);
    rdc(`UOTG_OFF_ENABLES, 32'hFFFFFFFF, 32'hFD);
    wr(`UOTG_OFF_FLAGS, 32'hFF);
    bSessEnd <= 1'b1;
    pin_flags(32'h14);
    check(32'(irq), 32'h1);
    wr(`UOTG_OFF_FLAGS, 32'h04);
    rdc(`UOTG_OFF_FLAGS, 32'h9D, 32'h10);
    bSessEnd <= 1'b0;
    pin_flags(32'h14);
    apb(1'b1, `UOTG_OFF_FLAGS, 32'h0, 4'h1);
    rdc(`UOTG_OFF_FLAGS, 32'h9D, 32'h0);
    idPin <= 1'b0;
    pin_flags(32'h80);
    aBusValid <= 1'b1;
    pin_flags(32'h91);
    aSessEnd <= 1'b1;
    pin_flags(32'h99);
    wr(`UOTG_OFF_FLAGS, 32'hFF);
    dPlus <= 1'b0;
    pin_flags(32'h10);
    waitc(MS + 10);
    rdc(`UOTG_OFF_FLAGS, 32'h20, 32'h20);
    dMinus <= 1'b1;
    lowSpeed <= 1'b1;
    waitc(4);
    rdc(`UOTG_OFF_STATUS, 32'h3, 32'h2);
    lowSpeed <= 1'b0;
    rdc(`UOTG_OFF_STATUS, 32'h3, 32'h0);
    wr(`UOTG_OFF_ENABLES, 32'h0);
    waitc(2);
    check(32'(irq), 32'h0);
    wr(`UOTG_OFF_ENABLES, 32'h40);
    wr(`UOTG_OFF_FLAGS, 32'hFF);
    waitc(MS + 5);
    rdc(`UOTG_OFF_FLAGS, 32'h40, 32'h40);
    check(32'(irq), 32'h1);
    finish_test();
  end
endmodule // test_usb_otg_host_token_config_irq
